// File: shared/pirq_consts.vh
`ifndef PIRQ_CONSTS_VH
`define PIRQ_CONSTS_VH
// register byte offsets
`define PIRQ_OFS_EN1    8'h00
`define PIRQ_OFS_EN2    8'h04
`define PIRQ_OFS_EN3    8'h08
`define PIRQ_OFS_PRI1   8'h0C
`define PIRQ_OFS_PRI2   8'h10
`define PIRQ_OFS_PRI3   8'h14
`define PIRQ_OFS_RCTL   8'h18
`define PIRQ_OFS_CTL1   8'h1C
`define PIRQ_OFS_CTL2   8'h20
`define PIRQ_OFS_CTL3   8'h24
// implemented-bit masks
`define PIRQ_MSK_EN1    8'h7F
`define PIRQ_MSK_EN2    8'h95
`define PIRQ_MSK_EN3    8'h1F
`define PIRQ_MSK_RCTL   8'h93
`define PIRQ_MSK_CTL1   8'hD2
`define PIRQ_MSK_CTL2   8'h70
`define PIRQ_MSK_CTL3   8'hDB
// reset values
`define PIRQ_RST_EN     8'h00
`define PIRQ_RST_PRI1   8'h7F
`define PIRQ_RST_PRI2   8'h95
`define PIRQ_RST_PRI3   8'h1F
`define PIRQ_RST_RCTL   8'h10
`define PIRQ_RST_CTL1   8'h00
`define PIRQ_RST_CTL2   8'h70
`define PIRQ_RST_CTL3   8'hC0
// field positions
`define PIRQ_B_PRIO_EN  7
`define PIRQ_B_WDT      3
`define PIRQ_B_SLP      2
`define PIRQ_B_GLOB_EN  7
`define PIRQ_B_PGATE    6
`define PIRQ_B_E0IE     4
`define PIRQ_B_E0IF     1
`define PIRQ_B_EDGE0    6
`define PIRQ_B_EDGE1    5
`define PIRQ_B_EDGE2    4
`define PIRQ_B_E2IP     7
`define PIRQ_B_E1IP     6
`define PIRQ_B_E2IE     4
`define PIRQ_B_E1IE     3
`define PIRQ_B_E2IF     1
`define PIRQ_B_E1IF     0
// bus answers
`define PIRQ_RESP_OKAY  2'h0
`define PIRQ_RESP_SLVERR 2'h2
`endif

// File: design/pirq_ctrl.v
// Operation
// - legacy mode: peripheral requests need the peripheral gate besides their enable
// - enable reg 1: seven rw enables at bits 6..0, bit 7 reads zero
// - enable reg 2: enables at bits 7,4,2,0, other bits read zero
// - enable reg 3: enables at bits 4..0, bits 7..5 read zero
// - reg 3 bits 3,2 gate capture or encoder sources per encoder mode
// - per-source priority bits matter only while priority mode is on
// - priority reg 1: bits 6..0 reset to one, bit 7 reads zero
// - priority regs 2,3 mirror enable layout, reset one, holes read zero
// - priority mode enable at reset-control bit 7, resets to zero
// - reset-control bits 4..0 cause flags, bits 3,2 read-only, 6,5 zero
// - external pins are edge detected, select bit one means rising
// - selected edge sets pin flag; clear enable blocks the request
// - enabled external pin interrupt wakes the core from idle or sleep
// - after wake, vector only if global enable set, else continue
// - ext 1 and 2 priorities at control-three bits 6 and 7
// - ext 0 is always high priority
// - flags set on their event regardless of any enable
// - global enable at bit 7 of the main control register
`timescale 1ns/1ps
`include "pirq_consts.vh"
module pirq_ctrl (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [6:0]  pir1_flags,
  input  wire [3:0]  pir2_flags,
  input  wire [2:0]  pir3_flags,
  input  wire        cap3_flag,
  input  wire        dir_flag,
  input  wire        cap2_flag,
  input  wire        enc_flag,
  input  wire [2:0]  encoder_mode_field,
  input  wire        watchdog_expired_flag,
  input  wire        sleep_entered_flag,
  input  wire [2:0]  ext_irq_pin,
  input  wire        core_low_power,
  output reg         irq_high,
  output reg         irq_low,
  output reg         wake_up,
  output reg         wake_vector
);

////////////////////////////////////////////////////////////////////////////////
// register state
reg  [7:0] en1_q;
reg  [7:0] en2_q;
reg  [7:0] en3_q;
reg  [7:0] pri1_q;
reg  [7:0] pri2_q;
reg  [7:0] pri3_q;
reg  [7:0] rctl_q;
reg  [7:0] ctl1_q;
reg  [7:0] ctl2_q;
reg  [7:0] ctl3_q;
reg  [2:0] wake_en_q;
// write channel holding
reg        aw_held_q;
reg  [7:0] aw_addr_q;
reg        w_held_q;
reg  [7:0] w_data_q;
reg        w_strb_q;
// pin synchronisers and edge history
reg  [2:0] pin_s1_q;
reg  [2:0] pin_s2_q;
reg  [2:0] pin_prev_q;

////////////////////////////////////////////////////////////////////////////////
// axi write path: address and data accepted independently
assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

wire       do_write = aw_held_q && w_held_q && !s_axi_bvalid;
wire       wr_byte  = do_write && w_strb_q;
wire [7:0] wd       = w_data_q;

// address decode for writes
wire wr_en1  = wr_byte && (aw_addr_q == `PIRQ_OFS_EN1);
wire wr_en2  = wr_byte && (aw_addr_q == `PIRQ_OFS_EN2);
wire wr_en3  = wr_byte && (aw_addr_q == `PIRQ_OFS_EN3);
wire wr_pri1 = wr_byte && (aw_addr_q == `PIRQ_OFS_PRI1);
wire wr_pri2 = wr_byte && (aw_addr_q == `PIRQ_OFS_PRI2);
wire wr_pri3 = wr_byte && (aw_addr_q == `PIRQ_OFS_PRI3);
wire wr_rctl = wr_byte && (aw_addr_q == `PIRQ_OFS_RCTL);
wire wr_ctl1 = wr_byte && (aw_addr_q == `PIRQ_OFS_CTL1);
wire wr_ctl2 = wr_byte && (aw_addr_q == `PIRQ_OFS_CTL2);
wire wr_ctl3 = wr_byte && (aw_addr_q == `PIRQ_OFS_CTL3);

// the map is dense: every aligned word up to control three is a register
function mapped;
  input [7:0] a;
  mapped = (a[1:0] == 2'h0) && (a <= `PIRQ_OFS_CTL3);
endfunction

// hold address/data until the pair is complete, then answer once
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_held_q    <= 1'b0;
    aw_addr_q    <= 8'h00;
    w_held_q     <= 1'b0;
    w_data_q     <= 8'h00;
    w_strb_q     <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp  <= `PIRQ_RESP_OKAY;
  end
  else if (clk_en)
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb_q <= s_axi_wstrb[0]; // only the low lane carries data
    end
    if (do_write)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_q) ? `PIRQ_RESP_OKAY : `PIRQ_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// external pins: two-flop synchroniser then edge detect
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    pin_s1_q   <= 3'h0;
    pin_s2_q   <= 3'h0;
    pin_prev_q <= 3'h0;
  end
  else if (clk_en)
  begin
    pin_s1_q   <= ext_irq_pin;
    pin_s2_q   <= pin_s1_q;
    pin_prev_q <= pin_s2_q;
  end
end

wire [2:0] edge_sel = {ctl2_q[`PIRQ_B_EDGE2], ctl2_q[`PIRQ_B_EDGE1],
                       ctl2_q[`PIRQ_B_EDGE0]};
wire [2:0] ext_edge;

// one comparator per pin; history flop keeps a held level from retriggering
genvar gi;
generate
  for (gi = 0; gi < 3; gi = gi + 1)
  begin : g_edge
    assign ext_edge[gi] = edge_sel[gi] ?
      (pin_s2_q[gi] && !pin_prev_q[gi]) :
      (!pin_s2_q[gi] && pin_prev_q[gi]);
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// main control: global enable, peripheral gate, ext 0 enable and flag
// a pin edge in the same cycle as a software clear still sets the flag
always @(posedge aclk)
begin
  if (!aresetn)
    ctl1_q <= `PIRQ_RST_CTL1;
  else if (clk_en)
  begin
    if (wr_ctl1)
      ctl1_q <= wd & `PIRQ_MSK_CTL1;
    if (ext_edge[0])
      ctl1_q[`PIRQ_B_E0IF] <= 1'b1;
  end
end

// edge selects
always @(posedge aclk)
begin
  if (!aresetn)
    ctl2_q <= `PIRQ_RST_CTL2;
  else if (clk_en && wr_ctl2)
    ctl2_q <= wd & `PIRQ_MSK_CTL2;
end

// ext 1/2 priority, enable and flag
always @(posedge aclk)
begin
  if (!aresetn)
    ctl3_q <= `PIRQ_RST_CTL3;
  else if (clk_en)
  begin
    if (wr_ctl3)
      ctl3_q <= wd & `PIRQ_MSK_CTL3;
    if (ext_edge[1])
      ctl3_q[`PIRQ_B_E1IF] <= 1'b1;
    if (ext_edge[2])
      ctl3_q[`PIRQ_B_E2IF] <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// enable and priority registers; unimplemented bits masked to zero
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    en1_q  <= `PIRQ_RST_EN;
    en2_q  <= `PIRQ_RST_EN;
    en3_q  <= `PIRQ_RST_EN;
    pri1_q <= `PIRQ_RST_PRI1;
    pri2_q <= `PIRQ_RST_PRI2;
    pri3_q <= `PIRQ_RST_PRI3;
  end
  else if (clk_en)
  begin
    if (wr_en1)
      en1_q <= wd & `PIRQ_MSK_EN1;
    if (wr_en2)
      en2_q <= wd & `PIRQ_MSK_EN2;
    if (wr_en3)
      en3_q <= wd & `PIRQ_MSK_EN3;
    if (wr_pri1)
      pri1_q <= wd & `PIRQ_MSK_EN1;
    if (wr_pri2)
      pri2_q <= wd & `PIRQ_MSK_EN2;
    if (wr_pri3)
      pri3_q <= wd & `PIRQ_MSK_EN3;
  end
end

// reset control: writable bits only; bits 3,2 mirror their sources
// cause-flag semantics live with the reset block, not here
always @(posedge aclk)
begin
  if (!aresetn)
    rctl_q <= `PIRQ_RST_RCTL;
  else if (clk_en && wr_rctl)
    rctl_q <= wd & `PIRQ_MSK_RCTL;
end

wire [7:0] rctl_rd = rctl_q |
  ({7'h00, watchdog_expired_flag} << `PIRQ_B_WDT) |
  ({7'h00, sleep_entered_flag} << `PIRQ_B_SLP);

////////////////////////////////////////////////////////////////////////////////
// axi read path: one cycle from address to data
assign s_axi_arready = !s_axi_rvalid;
reg [7:0] rd_mux;
always @*
begin
  rd_mux = 8'h00;
  case (s_axi_araddr)
    `PIRQ_OFS_EN1:  rd_mux = en1_q;
    `PIRQ_OFS_EN2:  rd_mux = en2_q;
    `PIRQ_OFS_EN3:  rd_mux = en3_q;
    `PIRQ_OFS_PRI1: rd_mux = pri1_q;
    `PIRQ_OFS_PRI2: rd_mux = pri2_q;
    `PIRQ_OFS_PRI3: rd_mux = pri3_q;
    `PIRQ_OFS_RCTL: rd_mux = rctl_rd;
    `PIRQ_OFS_CTL1: rd_mux = ctl1_q;
    `PIRQ_OFS_CTL2: rd_mux = ctl2_q;
    `PIRQ_OFS_CTL3: rd_mux = ctl3_q;
    default:        rd_mux = 8'h00;
  endcase
end

// upper 24 bits always read zero
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h00000000;
    s_axi_rresp  <= `PIRQ_RESP_OKAY;
  end
  else if (clk_en)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_mux};
      s_axi_rresp  <= mapped(s_axi_araddr) ? `PIRQ_RESP_OKAY : `PIRQ_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// peripheral sources: 7 + 4 + 5 flags, enables and priorities
wire enc_mode = (encoder_mode_field != 3'h0);
// shared bits follow whichever function the capture/encoder unit runs
wire src3 = enc_mode ? dir_flag : cap3_flag;
wire src2 = enc_mode ? enc_flag : cap2_flag;
wire [15:0] p_flag = {pir3_flags[2], src3, src2, pir3_flags[1:0],
                      pir2_flags, pir1_flags};
wire [15:0] p_en   = {en3_q[4:0], en2_q[7], en2_q[4], en2_q[2],
                      en2_q[0], en1_q[6:0]};
wire [15:0] p_pri  = {pri3_q[4:0], pri2_q[7], pri2_q[4], pri2_q[2],
                      pri2_q[0], pri1_q[6:0]};
wire [15:0] p_act  = p_flag & p_en;
wire        prio   = rctl_q[`PIRQ_B_PRIO_EN];
// in legacy mode priority bits are ignored
wire p_hi = prio ? |(p_act & p_pri) : 1'b0;
wire p_lo = prio ? |(p_act & ~p_pri) : 1'b0;
wire p_any = |p_act;

////////////////////////////////////////////////////////////////////////////////
// external sources
wire e0 = ctl1_q[`PIRQ_B_E0IF] && ctl1_q[`PIRQ_B_E0IE];
wire e1 = ctl3_q[`PIRQ_B_E1IF] && ctl3_q[`PIRQ_B_E1IE];
wire e2 = ctl3_q[`PIRQ_B_E2IF] && ctl3_q[`PIRQ_B_E2IE];

wire e1p = ctl3_q[`PIRQ_B_E1IP];
wire e2p = ctl3_q[`PIRQ_B_E2IP];

// ext 0 has no priority bit and always lands on the high level
wire e_hi = e0 || (e1 && e1p) || (e2 && e2p);
wire e_lo = (e1 && !e1p) || (e2 && !e2p);
wire e_any = e0 || e1 || e2;
wire glob_en = ctl1_q[`PIRQ_B_GLOB_EN];
wire pgate   = ctl1_q[`PIRQ_B_PGATE];
// legacy: one request, peripherals behind the gate
// priority mode: gate bit acts as the low-level enable
wire hi_d = prio ? (glob_en && (e_hi || p_hi))
                 : (glob_en && (e_any || (pgate && p_any)));
wire lo_d = prio ? (glob_en && pgate && (e_lo || p_lo)) : 1'b0;

////////////////////////////////////////////////////////////////////////////////
// wake-up: enables are snapshot when the core enters low power
reg  low_q;
wire enter_low = core_low_power && !low_q;
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    low_q     <= 1'b0;
    wake_en_q <= 3'h0;
  end
  else if (clk_en)
  begin
    low_q <= core_low_power;
    if (enter_low)
      wake_en_q <= {ctl3_q[`PIRQ_B_E2IE], ctl3_q[`PIRQ_B_E1IE],
                    ctl1_q[`PIRQ_B_E0IE]};
  end
end

// only enables armed at entry count; a flag pending at entry wakes at once
wire [2:0] ext_flags = {ctl3_q[`PIRQ_B_E2IF], ctl3_q[`PIRQ_B_E1IF],
                        ctl1_q[`PIRQ_B_E0IF]};
wire wake_d = low_q && |(ext_flags & wake_en_q);

// registered request and wake outputs
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    irq_high    <= 1'b0;
    irq_low     <= 1'b0;
    wake_up     <= 1'b0;
    wake_vector <= 1'b0;
  end
  else if (clk_en)
  begin
    irq_high    <= hi_d;
    irq_low     <= lo_d;
    wake_up     <= wake_d;
    wake_vector <= wake_d && glob_en;
  end
end

endmodule // pirq_ctrl

// File: tb/pirq_ctrl_properties.sv
`timescale 1ns/1ps
module pirq_ctrl_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        core_low_power,
  input wire        wake_up,
  input wire        wake_vector
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // bus handshakes as named steps
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r; s_axi_rvalid && s_axi_rready; endsequence
  sequence s_b; s_axi_bvalid && s_axi_bready; endsequence
  // exactly one answer per request, the next cycle for reads
  property p_rd_answer; s_ar |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_rd_once; s_r |=> !s_axi_rvalid; endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answered twice");
  property p_wr_once; s_b |=> !s_axi_bvalid; endproperty
  a_wr_once: assert property (p_wr_once) else $error("write answered twice");
  // a pending response blocks new write traffic
  property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
  // registers are one byte wide, the rest of the word reads zero
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  // wake trails the core state through the entry flop and the output flop
  property p_wake_cause; wake_up |-> $past(core_low_power, 2); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake while running");
  property p_wake_drop; !core_low_power |-> ##2 !wake_up; endproperty
  a_wake_drop: assert property (p_wake_drop) else $error("wake stuck");
  property p_vec_gate; wake_vector |-> wake_up; endproperty
  a_vec_gate: assert property (p_vec_gate) else $error("vector without wake");
endmodule // pirq_ctrl_chk

bind pirq_ctrl pirq_ctrl_chk chk_u (.*);

// File: tb/pirq_core_model.sv
`timescale 1ns/1ps
module pirq_core_model (
  input  logic aclk,
  input  logic aresetn,
  input  logic sleep_req,
  input  logic wake_up,
  input  logic wake_vector,
  output logic core_low_power,
  output int   vec_count
);
  // core naps on request and stays down until the wake line rises
  always @(posedge aclk)
    if (!aresetn)
      core_low_power <= 1'b0;
    else if (wake_up)
      core_low_power <= 1'b0;
    else if (sleep_req)
      core_low_power <= 1'b1;
  // one branch per wake; without vectoring the core just resumes
  always @(posedge aclk)
    if (!aresetn)
      vec_count <= 0;
    else if (wake_up && wake_vector && core_low_power)
      vec_count <= vec_count + 1;
endmodule // pirq_core_model

// File: tb/pirq_ctrl_tb.sv
`timescale 1ns/1ps
module peripheral_irq_enable_priority_tb_top;
  logic        aclk, aresetn, clk_en, sleep_req, ha, hw, hb, hr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d, r, o, b, f, e;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, pir2_flags;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0]  pir1_flags;
  logic [2:0]  pir3_flags, encoder_mode_field, ext_irq_pin;
  logic        cap3_flag, dir_flag, cap2_flag, enc_flag, watchdog_expired_flag;
  logic        sleep_entered_flag, core_low_power, irq_high, irq_low, wake_up, wake_vector;
  int          vec_count, i, j, k;
  int          bad_count = 0, n_compared = 0, cyc = 0;
  logic [7:0]  msk [7] = '{8'h7F, 8'h95, 8'h1F, 8'h7F, 8'h95, 8'h1F, 8'h93};
  logic [7:0]  rst [7] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h95, 8'h1F, 8'h10};

  pirq_ctrl dut_u (.*);
  pirq_core_model core_u (.aclk(aclk), .aresetn(aresetn), .sleep_req(sleep_req),
    .wake_up(wake_up), .wake_vector(wake_vector), .core_low_power(core_low_power),
    .vec_count(vec_count));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // masked write value plus the two cause inputs seen at reset-control
  function automatic logic [7:0] exp_reg(int idx, logic [7:0] v);
    exp_reg = (v & msk[idx]) | (idx == 6 ?
      {4'h0, watchdog_expired_flag, sleep_entered_flag, 2'h0} : 8'h00);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  // handshakes are judged at the falling edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    cmp("bresp", {30'h0, er}, {30'h0, rs});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ev, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      r = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!hr);
    if (er == 2'h0) cmp("rdata", {24'h0, ev}, {24'h0, r});
    cmp("rresp", {30'h0, er}, {30'h0, rs});
  endtask
  // requests are registered, so give them a few edges to settle
  task automatic chk_irq(input logic eh, input logic el);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    cmp("irq_high", {31'h0, eh}, {31'h0, irq_high});
    cmp("irq_low", {31'h0, el}, {31'h0, irq_low});
    @(posedge aclk);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; ready lines stay high so answers are taken at once
  initial
  begin
    k = $urandom(32'h8695);
    {clk_en, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
    {watchdog_expired_flag, sleep_entered_flag} = 2'($urandom);
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, pir1_flags, pir2_flags, pir3_flags, encoder_mode_field} = '0;
    {ext_irq_pin, cap3_flag, dir_flag, cap2_flag, enc_flag, sleep_req} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++)
      rd(8'(4 * i), exp_reg(i, rst[i]), 2'h0);
    rd(8'h1C, 8'h00, 2'h0);
    rd(8'h20, 8'h70, 2'h0);
    rd(8'h24, 8'hC0, 2'h0);
    for (i = 0; i < 7; i++)
    begin
      d = 8'($urandom) & (i == 6 ? 8'h7F : 8'hFF);
      wr(8'(4 * i), d, 2'h0);
      rd(8'(4 * i), exp_reg(i, d), 2'h0);
    end
    wr(8'h40, 8'hFF, 2'h2);
    rd(8'h40, 8'h00, 2'h2);
    $display("test registers done");
    // one peripheral source through mode, priority, gate and global enable
    k = $urandom_range(6);
    pir1_flags <= 7'h01 << k;
    wr(8'h00, 8'h01 << k, 2'h0);
    for (i = 0; i < 16; i++)
    begin
      wr(8'h18, {i[2], 7'h00}, 2'h0);
      wr(8'h0C, i[1] ? 8'h00 : 8'h7F, 2'h0);
      wr(8'h1C, {i[3], i[0], 6'h00}, 2'h0);
      chk_irq(i[3] & (i[2] ? !i[1] : i[0]), i[3] & i[2] & i[1] & i[0]);
    end
    $display("test peripheral done");
    // bit 3 of enable three gates direction change only in encoder mode
    pir1_flags <= 7'h00;
    dir_flag <= 1'b1;
    wr(8'h18, 8'h00, 2'h0);
    wr(8'h08, 8'h08, 2'h0);
    wr(8'h1C, 8'hC0, 2'h0);
    for (i = 0; i < 2; i++)
    begin
      encoder_mode_field <= i ? 3'($urandom_range(7, 1)) : 3'h0;
      chk_irq(i[0], 1'b0);
    end
    dir_flag <= 1'b0;
    $display("test encoder done");
    // each pin and edge: flag without enable, priority, then the wrong edge
    wr(8'h18, 8'h80, 2'h0);
    wr(8'h08, 8'h00, 2'h0);
    for (i = 0; i < 3; i++)
      for (j = 0; j < 2; j++)
      begin
        o = i == 0 ? 8'h1C : 8'h24;
        b = i == 0 ? 8'hC0 : 8'h00;
        f = i == 0 ? 8'h02 : 8'h01 << (i - 1);
        e = i == 0 ? 8'h10 : 8'h08 << (i - 1);
        wr(8'h20, j ? 8'h40 >> i : 8'h00, 2'h0);
        ext_irq_pin[i] <= !j;
        repeat (4) @(posedge aclk);
        wr(o, b, 2'h0);
        ext_irq_pin[i] <= j[0];
        repeat (4) @(posedge aclk);
        rd(o, b | f, 2'h0);
        wr(o, b | f | e, 2'h0);
        chk_irq(i == 0, i != 0);
        wr(o, b, 2'h0);
        ext_irq_pin[i] <= !j;
        repeat (4) @(posedge aclk);
        rd(o, b, 2'h0);
      end
    $display("test pins done");
    // armed pin wakes the core; it vectors only with the global enable
    wr(8'h20, 8'h40, 2'h0);
    for (j = 0; j < 2; j++)
    begin
      wr(8'h1C, j ? 8'h90 : 8'h10, 2'h0);
      k = vec_count;
      sleep_req <= 1'b1;
      @(posedge aclk);
      sleep_req <= 1'b0;
      @(negedge aclk);
      cmp("asleep", 32'h1, {31'h0, core_low_power});
      @(posedge aclk);
      ext_irq_pin[0] <= 1'b1;
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      cmp("awake", 32'h0, {31'h0, core_low_power});
      cmp("vectors", 32'(j), 32'(vec_count - k));
      @(posedge aclk);
      ext_irq_pin[0] <= 1'b0;
      wr(8'h1C, 8'h00, 2'h0);
    end
    $display("test wake done");
    // a low clock enable freezes the pin path; the edge lands once it returns
    wr(8'h1C, 8'h90, 2'h0);
    clk_en <= 1'b0;
    ext_irq_pin[0] <= 1'b1;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    cmp("frozen", 32'h0, {31'h0, irq_high});
    @(posedge aclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_irq(1'b1, 1'b0);
    $display("test freeze done");
    end_sim();
  end
endmodule // peripheral_irq_enable_priority_tb_top
